// file: rtl/opmc_pkg.sv
`default_nettype none

package opmc_pkg;

  // ----------------------------------------------------------------
  // register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TRIM = 8'h08;

  localparam int CTRL_HIB_BIT = 0;
  localparam int CTRL_LSO_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam logic CTRL_HIB_RST = 1'h0;
  localparam logic CTRL_LSO_RST = 1'h0;

  localparam int ST_OP_LSB = 0;
  localparam int ST_PWR_LSB = 4;
  localparam int ST_CAUSE_LSB = 8;
  localparam int ST_LPOK_BIT = 12;
  localparam int ST_ACQ_BIT = 13;
  localparam int ST_PEND_BIT = 14;

  localparam logic [31:0] TRIM_RST = 32'h0000_0000;
  localparam logic [1:0] PROT_OPEN = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ACQ_WIN_NS = 400;
  localparam int ACQ_WIN_CYC = (ACQ_WIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WIN_W = 12;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OPM_BOOT = 2'h0,
    OPM_USER = 2'h1,
    OPM_PRIV = 2'h3,
    OPM_DEBUG = 2'h2
  } opmc_op_e;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'h0,
    PWR_SLEEP = 3'h1,
    PWR_DEEP = 3'h3,
    PWR_HIB = 3'h2,
    PWR_STOP = 3'h6
  } opmc_pwr_e;

  typedef enum logic [1:0] {
    CAUSE_NONE = 2'h0,
    CAUSE_IRQ = 2'h1,
    CAUSE_RESET = 2'h2
  } opmc_cause_e;

  typedef struct packed {
    logic pin_irq;
    logic lpcomp;
    logic serial;
    logic wdt_irq;
    logic wdt_rst;
    logic wakeup_pin;
  } opmc_wake_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic hf_clk_en;
    logic sys_clk_en;
    logic lso_en;
    logic async_en;
    logic lpcomp_en;
    logic sup_on;
    logic ret_cpu;
    logic ret_sram;
    logic ret_pdb;
    logic ret_hs;
    logic gpio_freeze;
  } opmc_gate_s;

endpackage

`default_nettype wire

// file: rtl/opmc_top.sv
// Functional notes
// R1 - after reset go to boot, or to debug if an acquire arrived in reset
// R2 - interrupts stay disabled throughout boot mode
// R3 - boot loads trim settings from flash before normal operation
// R4 - boot completion switches to user mode with flash fetch
// R5 - user mode blocks instruction fetch from the supervisory ROM
// R6 - privileged only via system call; leaving it returns to user
// R7 - no debugger access or observation while privileged
// R8 - debugger must connect within the acquire window during reset
// R9 - debug entry only when protection is in open mode
// R10 - five power modes: Active, Sleep, Deep-Sleep, Hibernate, Stop
// R11 - wakeup from Hibernate or Stop resets CPU and peripherals
// R12 - Sleep stops CPU clock only; any enabled interrupt wakes
// R13 - Deep-Sleep retains CPU, SRAM, digital blocks, high-speed logic
// R14 - Deep-Sleep gates high-frequency and system clocks
// R15 - Deep-Sleep may keep the low-speed oscillator running
// R16 - clockless and interface-clocked peripherals run in Deep-Sleep
// R17 - low-speed, async or analog interrupts wake Deep-Sleep as interrupt
// R18 - Hibernate keeps SRAM and blocks; pin or comparator wake by reset
// R19 - Stop keeps only GPIO state; wakeup pin wakes by reset
// R20 - external reset or brownout returns to Active from any mode
// R21 - wait-for-irq picks Sleep, Deep-Sleep or Hibernate from selects
// R22 - low-power request before regulators ready goes via Sleep
// R23 - one power mode and one operational mode, reset to boot/Active
// R24 - wake cause tells interrupt wakeups from reset wakeups
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module opmc_top
  import opmc_pkg::*;
#(
  parameter int ACQ_CYC = ACQ_WIN_CYC,
  parameter logic [1:0] PROT_OPEN_CODE = PROT_OPEN
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // cpu
  input wire logic WAIT_FOR_IRQ_INSTRUCTION,
  input wire logic DEEP_SLEEP_SELECT,
  input wire logic SYSCALL_ENTER,
  input wire logic SYSCALL_EXIT,
  input wire logic IRQ_PENDING,
  output logic IRQ_ENABLE,
  output logic FLASH_FETCH_EN,
  output logic SUPERVISORY_ROM_FETCH_EN,
  // debugger and protection
  input wire logic SWD_ACQUIRE,
  input wire logic [1:0] PROT_MODE,
  output logic DEBUG_ACCESS_EN,
  // trim load from flash
  output logic TRIM_REQ,
  input wire logic TRIM_ACK,
  input wire logic [31:0] TRIM_DATA,
  output logic [31:0] TRIM_VALUE,
  // wakeup and reset sources
  input wire opmc_wake_s WAKE_SRC,
  input wire logic EXTERNAL_RESET_PIN,
  input wire logic BROWNOUT,
  input wire logic LOWPOWER_REGULATORS_OK,
  // mode, gating and reset outputs
  output opmc_op_e OP_MODE,
  output opmc_pwr_e POWER_MODE,
  output opmc_gate_s GATE,
  output opmc_cause_e WAKE_CAUSE,
  output logic SYS_RESET,
  output logic KEEP_IRQ_STATE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  opmc_op_e op_ff;
  opmc_pwr_e pwr_ff;
  opmc_cause_e cause_ff;
  logic [WIN_W-1:0] win_cnt_ff;
  logic acq_ff;
  logic trim_done_ff;
  logic trim_req_ff;
  logic [31:0] trim_ff;
  logic pend_ff;
  logic pend_hib_ff;
  logic hib_sel_ff;
  logic lso_keep_ff;
  logic sys_rst_ff;
  logic keep_irq_ff;
  logic [31:0] prdata_ff;

  logic wr_en;
  logic stop_wr;
  logic cause_clr;
  logic wake_rst;
  logic hib_wake;
  logic sys_rst_req;
  logic irq_wake;
  logic win_open;

  function automatic logic addr_hit(logic [APB_AW-1:0] a);
    addr_hit = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_TRIM);
  endfunction

  function automatic opmc_gate_s pwr_gate(opmc_pwr_e m, logic lso_keep);
    opmc_gate_s g;
    g = '0;
    unique case (m)
      PWR_ACTIVE: begin
        g.cpu_clk_en = 1'b1;
        g.hf_clk_en = 1'b1;
        g.sys_clk_en = 1'b1;
        g.lso_en = 1'b1;
        g.async_en = 1'b1;
        g.lpcomp_en = 1'b1;
        g.sup_on = 1'b1;
      end
      PWR_SLEEP: begin
        // peripherals see exactly what they see in Active
        g.hf_clk_en = 1'b1;
        g.sys_clk_en = 1'b1;
        g.lso_en = 1'b1;
        g.async_en = 1'b1;
        g.lpcomp_en = 1'b1;
        g.sup_on = 1'b1;
        g.ret_cpu = 1'b1;
        g.ret_sram = 1'b1;
      end
      PWR_DEEP: begin
        g.lso_en = lso_keep; // [R15]
        g.async_en = 1'b1; // [R16]
        g.lpcomp_en = 1'b1;
        g.ret_cpu = 1'b1; // [R13]
        g.ret_sram = 1'b1;
        g.ret_pdb = 1'b1;
        g.ret_hs = 1'b1;
      end
      PWR_HIB: begin
        g.lpcomp_en = 1'b1;
        g.ret_sram = 1'b1; // [R18]
        g.ret_pdb = 1'b1;
        g.gpio_freeze = 1'b1;
      end
      PWR_STOP: begin
        g.gpio_freeze = 1'b1; // [R19]
      end
      default: g = '0;
    endcase
    return g;
  endfunction

  // ----------------------------------------------------------------
  // apb slave: zero wait states, read data captured in setup
  // ----------------------------------------------------------------
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);
  assign wr_en = PSEL && PENABLE && PWRITE && addr_hit(PADDR);
  assign stop_wr = wr_en && (PADDR == REG_CTRL) && PWDATA[CTRL_STOP_BIT];
  assign cause_clr = wr_en && (PADDR == REG_STATUS) && (PWDATA[ST_CAUSE_LSB+:2] != 2'h0);
  assign PRDATA = prdata_ff;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      prdata_ff <= '0;
    end else if (PSEL && !PENABLE) begin
      prdata_ff <= '0;
      unique case (PADDR)
        REG_CTRL: begin
          prdata_ff[CTRL_HIB_BIT] <= hib_sel_ff;
          prdata_ff[CTRL_LSO_BIT] <= lso_keep_ff;
        end
        REG_STATUS: begin
          prdata_ff[ST_OP_LSB+:2] <= op_ff;
          prdata_ff[ST_PWR_LSB+:3] <= pwr_ff;
          prdata_ff[ST_CAUSE_LSB+:2] <= cause_ff;
          prdata_ff[ST_LPOK_BIT] <= LOWPOWER_REGULATORS_OK;
          prdata_ff[ST_ACQ_BIT] <= acq_ff;
          prdata_ff[ST_PEND_BIT] <= pend_ff;
        end
        REG_TRIM: prdata_ff <= trim_ff;
        default: prdata_ff <= '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      hib_sel_ff <= CTRL_HIB_RST;
      lso_keep_ff <= CTRL_LSO_RST;
    end else if (wr_en && (PADDR == REG_CTRL)) begin
      hib_sel_ff <= PWDATA[CTRL_HIB_BIT];
      lso_keep_ff <= PWDATA[CTRL_LSO_BIT];
    end
  end

  // ----------------------------------------------------------------
  // reset and wakeup sources
  // ----------------------------------------------------------------
  assign hib_wake = (pwr_ff == PWR_HIB) && (WAKE_SRC.pin_irq || WAKE_SRC.lpcomp); // [R18]
  assign wake_rst = hib_wake // [R11]
                  || ((pwr_ff == PWR_STOP) && WAKE_SRC.wakeup_pin) // [R19]
                  || ((pwr_ff == PWR_DEEP) && WAKE_SRC.wdt_rst);
  assign sys_rst_req = EXTERNAL_RESET_PIN || BROWNOUT || wake_rst; // [R20]
  assign irq_wake = ((pwr_ff == PWR_SLEEP) && IRQ_PENDING) // [R12]
                  || ((pwr_ff == PWR_DEEP) && (WAKE_SRC.pin_irq || WAKE_SRC.lpcomp
                     || WAKE_SRC.serial || WAKE_SRC.wdt_irq)); // [R17]

  // reset pulse to CPU and peripherals; held while EXTERNAL_RESET_PIN or BROWNOUT is held, one cycle for a wake reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sys_rst_ff <= 1'b0;
      keep_irq_ff <= 1'b0;
    end else begin
      sys_rst_ff <= sys_rst_req; // [R11]
      keep_irq_ff <= hib_wake && !EXTERNAL_RESET_PIN && !BROWNOUT; // [R18]
    end
  end

  // ----------------------------------------------------------------
  // debug acquire window, opened by every reset
  // ----------------------------------------------------------------
  assign win_open = (win_cnt_ff != '0);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      win_cnt_ff <= WIN_W'(ACQ_CYC);
      acq_ff <= 1'b0;
    end else if (sys_rst_req) begin
      win_cnt_ff <= WIN_W'(ACQ_CYC); // [R8]
      acq_ff <= 1'b0;
    end else begin
      if (win_open) begin
        win_cnt_ff <= win_cnt_ff - WIN_W'(1);
      end
      // a locked part ignores the acquire, so the debugger is refused
      if (win_open && SWD_ACQUIRE && (PROT_MODE == PROT_OPEN_CODE)) begin // [R8] [R9]
        acq_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // boot trim load
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      trim_req_ff <= 1'b0;
      trim_done_ff <= 1'b0;
      trim_ff <= TRIM_RST;
    end else if (sys_rst_req) begin
      trim_req_ff <= 1'b0;
      trim_done_ff <= 1'b0;
    end else if (trim_req_ff) begin
      if (TRIM_ACK) begin
        trim_ff <= TRIM_DATA; // [R3]
        trim_done_ff <= 1'b1;
        trim_req_ff <= 1'b0;
      end
    end else if (op_ff == OPM_BOOT && !win_open && !acq_ff && !trim_done_ff) begin
      trim_req_ff <= 1'b1; // [R3]
    end
  end

  assign TRIM_REQ = trim_req_ff;
  assign TRIM_VALUE = trim_ff;

  // ----------------------------------------------------------------
  // operational mode
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      op_ff <= OPM_BOOT; // [R23]
    end else if (sys_rst_req) begin
      op_ff <= OPM_BOOT; // [R1]
    end else begin
      unique case (op_ff)
        OPM_BOOT: begin
          if (!win_open && acq_ff) begin
            op_ff <= OPM_DEBUG; // [R1]
          end else if (trim_done_ff) begin
            op_ff <= OPM_USER; // [R4]
          end
        end
        OPM_USER: begin
          if (SYSCALL_ENTER) begin
            op_ff <= OPM_PRIV; // [R6]
          end
        end
        OPM_PRIV: begin
          if (SYSCALL_EXIT) begin
            op_ff <= OPM_USER; // [R6]
          end
        end
        OPM_DEBUG: op_ff <= OPM_DEBUG;
      endcase
    end
  end

  // pure decodes of the mode flop, so they switch on the same edge
  assign IRQ_ENABLE = (op_ff != OPM_BOOT); // [R2]
  assign FLASH_FETCH_EN = (op_ff == OPM_USER) || (op_ff == OPM_DEBUG); // [R4]
  assign SUPERVISORY_ROM_FETCH_EN = (op_ff == OPM_BOOT) || (op_ff == OPM_PRIV); // [R5]
  assign DEBUG_ACCESS_EN = (op_ff == OPM_DEBUG); // [R7]
  assign OP_MODE = op_ff;

  // ----------------------------------------------------------------
  // power mode
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pwr_ff <= PWR_ACTIVE; // [R23]
      pend_ff <= 1'b0;
      pend_hib_ff <= 1'b0;
    end else if (sys_rst_req) begin
      pwr_ff <= PWR_ACTIVE; // [R20]
      pend_ff <= 1'b0;
    end else begin
      unique case (pwr_ff)
        PWR_ACTIVE: begin
          if (stop_wr) begin
            pwr_ff <= PWR_STOP; // [R10]
          end else if (WAIT_FOR_IRQ_INSTRUCTION) begin
            if (!DEEP_SLEEP_SELECT) begin
              pwr_ff <= PWR_SLEEP; // [R21]
            end else if (LOWPOWER_REGULATORS_OK) begin
              pwr_ff <= hib_sel_ff ? PWR_HIB : PWR_DEEP; // [R21]
            end else begin
              pwr_ff <= PWR_SLEEP; // [R22]
              pend_ff <= 1'b1;
              pend_hib_ff <= hib_sel_ff;
            end
          end
        end
        PWR_SLEEP: begin
          if (IRQ_PENDING) begin
            pwr_ff <= PWR_ACTIVE; // [R12]
            pend_ff <= 1'b0;
          end else if (pend_ff && LOWPOWER_REGULATORS_OK) begin
            pwr_ff <= pend_hib_ff ? PWR_HIB : PWR_DEEP; // [R22]
            pend_ff <= 1'b0;
          end
        end
        PWR_DEEP: begin
          if (irq_wake) begin
            pwr_ff <= PWR_ACTIVE; // [R17]
          end
        end
        // Hibernate and Stop only leave through a reset
        PWR_HIB: pwr_ff <= PWR_HIB;
        PWR_STOP: pwr_ff <= PWR_STOP;
        default: pwr_ff <= PWR_ACTIVE;
      endcase
    end
  end

  assign POWER_MODE = pwr_ff;
  assign GATE = pwr_gate(pwr_ff, lso_keep_ff); // [R14]

  // ----------------------------------------------------------------
  // wake cause; a new cause wins over a software clear
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cause_ff <= CAUSE_NONE;
    end else if (EXTERNAL_RESET_PIN) begin
      // full restart: the cause is deliberately lost
      cause_ff <= CAUSE_NONE;
    end else if (BROWNOUT || wake_rst) begin
      cause_ff <= CAUSE_RESET; // [R24]
    end else if (irq_wake) begin
      cause_ff <= CAUSE_IRQ; // [R24]
    end else if (cause_clr) begin
      cause_ff <= CAUSE_NONE;
    end
  end

  assign WAKE_CAUSE = cause_ff;
  assign SYS_RESET = sys_rst_ff;
  assign KEEP_IRQ_STATE = keep_irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_boot_irq;
    (op_ff == OPM_BOOT) |-> !IRQ_ENABLE;
  endproperty
  a_boot_irq: assert property (p_boot_irq) else $error("irq enabled in boot"); // [R2]

  property p_boot_trim;
    (op_ff == OPM_BOOT) ##1 (op_ff == OPM_USER) |-> $past(trim_done_ff);
  endproperty
  a_boot_trim: assert property (p_boot_trim) else $error("user without trim"); // [R3]

  property p_user_rom;
    (op_ff == OPM_USER) |-> !SUPERVISORY_ROM_FETCH_EN && FLASH_FETCH_EN;
  endproperty
  a_user_rom: assert property (p_user_rom) else $error("rom fetch in user"); // [R5]

  property p_priv_entry;
    (op_ff != OPM_PRIV) ##1 (op_ff == OPM_PRIV) |-> $past(SYSCALL_ENTER);
  endproperty
  a_priv_entry: assert property (p_priv_entry) else $error("priv without syscall"); // [R6]

  property p_priv_dbg;
    (op_ff == OPM_PRIV) |-> !DEBUG_ACCESS_EN;
  endproperty
  a_priv_dbg: assert property (p_priv_dbg) else $error("debug while priv"); // [R7]

  property p_acq_prot;
    $rose(acq_ff) |-> $past(PROT_MODE) == PROT_OPEN_CODE && $past(win_open);
  endproperty
  a_acq_prot: assert property (p_acq_prot) else $error("acquire not allowed"); // [R9]

  property p_sleep_clk;
    (pwr_ff == PWR_SLEEP) |-> !GATE.cpu_clk_en && GATE.hf_clk_en && GATE.sup_on;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("bad sleep gating"); // [R12]

  property p_deep_clk;
    (pwr_ff == PWR_DEEP) |-> !GATE.hf_clk_en && !GATE.sys_clk_en && GATE.ret_cpu;
  endproperty
  a_deep_clk: assert property (p_deep_clk) else $error("bad deep gating"); // [R14]

  property p_wfi_sleep;
    (pwr_ff == PWR_ACTIVE) && WAIT_FOR_IRQ_INSTRUCTION && !DEEP_SLEEP_SELECT
      && !stop_wr && !sys_rst_req |=> (pwr_ff == PWR_SLEEP);
  endproperty
  a_wfi_sleep: assert property (p_wfi_sleep) else $error("wfi did not sleep"); // [R21]

  property p_pend;
    (pwr_ff == PWR_SLEEP) && pend_ff && LOWPOWER_REGULATORS_OK && !IRQ_PENDING
      && !sys_rst_req |=> (pwr_ff == PWR_DEEP) || (pwr_ff == PWR_HIB);
  endproperty
  a_pend: assert property (p_pend) else $error("pending entry lost"); // [R22]

  property p_external_reset_pin;
    EXTERNAL_RESET_PIN |=> (pwr_ff == PWR_ACTIVE) && (op_ff == OPM_BOOT) && SYS_RESET;
  endproperty
  a_external_reset_pin: assert property (p_external_reset_pin) else $error("external_reset_pin not honoured"); // [R20]

  property p_hib_wake;
    hib_wake && !EXTERNAL_RESET_PIN && !BROWNOUT
      |=> SYS_RESET && KEEP_IRQ_STATE && (WAKE_CAUSE == CAUSE_RESET);
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate wake wrong"); // [R18]

  c_debug: cover property ((op_ff == OPM_BOOT) ##1 (op_ff == OPM_DEBUG));
  c_pend: cover property (pend_ff && (pwr_ff == PWR_SLEEP) ##1 (pwr_ff == PWR_HIB));
  c_deep_wake: cover property ((pwr_ff == PWR_DEEP) ##1 (WAKE_CAUSE == CAUSE_IRQ));

endmodule

`default_nettype wire

// file: sim/opmc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

module opmc_flash_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // access time and stored trim word
  input wire logic [3:0] lat,
  input wire logic [31:0] word,
  // trim read port
  input wire logic trim_req,
  output logic trim_ack,
  output logic [31:0] trim_data
);
  logic [3:0] cnt_ff;
  logic done_ff;

  // one ack per request; data bus toggles outside the ack so a stale value matches the word at most every other cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
      trim_ack <= 1'b0;
      trim_data <= 32'h0000_0000;
    end else if (trim_req && !done_ff) begin
      cnt_ff <= cnt_ff + 4'h1;
      trim_ack <= 1'b0;
      trim_data <= ~trim_data;
      if (cnt_ff >= lat) begin
        trim_ack <= 1'b1;
        trim_data <= word;
        done_ff <= 1'b1;
      end
    end else begin
      trim_ack <= 1'b0;
      trim_data <= ~trim_data;
      if (!trim_req) begin
        done_ff <= 1'b0;
        cnt_ff <= 4'h0;
      end
    end
  end
endmodule

`default_nettype wire

// file: sim/opmc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module operational_and_power_mode_controller_tb_top;
  import opmc_pkg::*;
  localparam logic [31:0] TW = 32'h5A3C_96E1;
  logic clk, rst, psel, penable, pwrite, wait_for_irq_instruction, dss, sc_en, sc_ex, irq_pend, swd, external_reset_pin, bod;
  logic lp_ok, pready, pslverr, irq_en, flash_en, rom_en, dbg_en, trim_req, trim_ack;
  logic sys_rst, keep_irq, saw_rst, saw_keep, saw_clr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, trim_val, trim_data, rd;
  logic [1:0] prot;
  logic [3:0] lat;
  opmc_wake_s wake;
  opmc_op_e op;
  opmc_pwr_e pwr;
  opmc_gate_s gate;
  opmc_cause_e cause;
  int fail_count, cmp_count;

  opmc_top #(.ACQ_CYC(4)) u_dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .WAIT_FOR_IRQ_INSTRUCTION(wait_for_irq_instruction), .DEEP_SLEEP_SELECT(dss),
    .SYSCALL_ENTER(sc_en), .SYSCALL_EXIT(sc_ex), .IRQ_PENDING(irq_pend), .IRQ_ENABLE(irq_en),
    .FLASH_FETCH_EN(flash_en), .SUPERVISORY_ROM_FETCH_EN(rom_en), .SWD_ACQUIRE(swd),
    .PROT_MODE(prot), .DEBUG_ACCESS_EN(dbg_en), .TRIM_REQ(trim_req), .TRIM_ACK(trim_ack),
    .TRIM_DATA(trim_data), .TRIM_VALUE(trim_val), .WAKE_SRC(wake), .EXTERNAL_RESET_PIN(external_reset_pin),
    .BROWNOUT(bod), .LOWPOWER_REGULATORS_OK(lp_ok), .OP_MODE(op), .POWER_MODE(pwr),
    .GATE(gate), .WAKE_CAUSE(cause), .SYS_RESET(sys_rst), .KEEP_IRQ_STATE(keep_irq));

  opmc_flash_model u_flash (.clk(clk), .rst(rst), .lat(lat), .word(TW),
    .trim_req(trim_req), .trim_ack(trim_ack), .trim_data(trim_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // one process owns the reset watchers; the sequence only drives saw_clr
  always @(posedge clk) begin
    if (saw_clr) begin
      saw_rst <= 1'b0;
      saw_keep <= 1'b0;
    end else if (sys_rst === 1'b1) begin
      saw_rst <= 1'b1;
      saw_keep <= saw_keep | keep_irq;
    end
  end

  // ----
  // helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
  endtask

  // state is sampled at the edge, before that edge's updates land
  task automatic wait_st(input opmc_op_e o, input opmc_pwr_e p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((op !== o || pwr !== p) && n < 300);
    chk("mode", {op, pwr}, {o, p});
    if (op !== o || pwr !== p) wrap_up();
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    {sc_ex, sc_en, wait_for_irq_instruction} <= 3'b1 << k;
    @(posedge clk);
    {sc_ex, sc_en, wait_for_irq_instruction} <= 3'b0;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask

  // ----
  // sequence
  // ----
  initial begin
    {psel, penable, pwrite, wait_for_irq_instruction, dss, sc_en, sc_ex, irq_pend, swd, external_reset_pin, bod, lp_ok} = '0;
    saw_clr = 1'b1;
    rst = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    prot = 2'h1;
    lat = 4'h8;
    wake = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("op_rst", {op, pwr}, {OPM_BOOT, PWR_ACTIVE});
    chk("irq_en_boot", irq_en, 1'b0);
    wait_st(OPM_USER, PWR_ACTIVE);
    chk("trim", trim_val, TW);
    chk("fetch", {irq_en, flash_en, rom_en}, 3'b110);
    lat <= 4'h0;
    pulse(1);
    wait_st(OPM_PRIV, PWR_ACTIVE);
    chk("dbg_priv", dbg_en, 1'b0);
    pulse(2);
    wait_st(OPM_USER, PWR_ACTIVE);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0002);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", rd, 32'h0000_0000);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("status", {rd[6:4], rd[1:0]}, {PWR_ACTIVE, OPM_USER});
    pulse(0);
    wait_st(OPM_USER, PWR_SLEEP);
    chk("sleep_clk", {gate.cpu_clk_en, gate.hf_clk_en}, 2'b01);
    irq_pend <= 1'b1;
    wait_st(OPM_USER, PWR_ACTIVE);
    irq_pend <= 1'b0;
    dss <= 1'b1;
    lp_ok <= 1'b1;
    pulse(0);
    wait_st(OPM_USER, PWR_DEEP);
    chk("deep_clk", {gate.hf_clk_en, gate.sys_clk_en, gate.lso_en}, 3'b001);
    chk("deep_ret", {gate.ret_cpu, gate.ret_sram, gate.ret_pdb, gate.ret_hs}, 4'hF);
    chk("deep_async", gate.async_en, 1'b1);
    wake.serial <= 1'b1;
    wait_st(OPM_USER, PWR_ACTIVE);
    chk("cause_irq", cause, CAUSE_IRQ);
    wake.serial <= 1'b0;
    lp_ok <= 1'b0;
    pulse(0);
    wait_st(OPM_USER, PWR_SLEEP);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("pending", rd[ST_PEND_BIT], 1'b1);
    lp_ok <= 1'b1;
    wait_st(OPM_USER, PWR_DEEP);
    external_reset_pin <= 1'b1;
    wait_st(OPM_BOOT, PWR_ACTIVE);
    external_reset_pin <= 1'b0;
    wait_st(OPM_USER, PWR_ACTIVE);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    pulse(0);
    wait_st(OPM_USER, PWR_HIB);
    chk("hib_ret", {gate.ret_cpu, gate.ret_sram, gate.ret_pdb}, 3'b011);
    wake.serial <= 1'b1;
    saw_clr <= 1'b1;
    repeat (5) @(posedge clk);
    chk("hib_hold", pwr, PWR_HIB);
    saw_clr <= 1'b0;
    wake <= 6'b100000;
    wait_st(OPM_BOOT, PWR_ACTIVE);
    repeat (2) @(posedge clk);
    chk("hib_wake", {saw_rst, saw_keep, cause}, {2'b11, CAUSE_RESET});
    wake <= '0;
    wait_st(OPM_USER, PWR_ACTIVE);
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    wait_st(OPM_USER, PWR_STOP);
    chk("stop_gate", {gate.sup_on, gate.gpio_freeze}, 2'b01);
    wake.pin_irq <= 1'b1;
    saw_clr <= 1'b1;
    repeat (5) @(posedge clk);
    chk("stop_hold", pwr, PWR_STOP);
    saw_clr <= 1'b0;
    wake <= 6'b000001;
    wait_st(OPM_BOOT, PWR_ACTIVE);
    repeat (2) @(posedge clk);
    chk("stop_wake", {saw_rst, saw_keep}, 2'b10);
    wake <= '0;
    wait_st(OPM_USER, PWR_ACTIVE);
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    wait_st(OPM_USER, PWR_STOP);
    bod <= 1'b1;
    wait_st(OPM_BOOT, PWR_ACTIVE);
    bod <= 1'b0;
    wait_st(OPM_USER, PWR_ACTIVE);
    swd <= 1'b1;
    prot <= PROT_OPEN;
    do_reset();
    wait_st(OPM_DEBUG, PWR_ACTIVE);
    chk("dbg_open", dbg_en, 1'b1);
    prot <= 2'h1;
    do_reset();
    wait_st(OPM_USER, PWR_ACTIVE);
    chk("dbg_locked", dbg_en, 1'b0);
    wrap_up();
  end
endmodule

`default_nettype wire
